// File: stc_pkg.sv
package stc_pkg;

	localparam int ADDR_W = 8;

	// register byte addresses on the bus
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_COUNT_LOW = 8'h04;
	localparam logic [7:0] OFF_COUNT_HIGH = 8'h08;
	localparam logic [7:0] OFF_FLAGS_ONE = 8'h0c;
	localparam logic [7:0] OFF_ENABLES_ONE = 8'h10;

	// reset values
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [7:0] HIGH_BUF_RST = 8'h00;

	// field positions
	localparam int OVF_FLAG_BIT = 0;
	localparam int OVF_IRQ_EN_BIT = 0;
	localparam logic [7:0] CONTROL_WMASK = 8'hbf;

	// compare unit mode that issues the special event trigger
	localparam logic [3:0] CMP_MODE_SPECIAL = 4'hb;

	// instruction cycle is four system clocks
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

	localparam logic [15:0] COUNT_MAX = 16'hffff;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic wideAccessEnable;
		logic unused6;
		logic [1:0] inputPrescaleSelect;
		logic lowPowerOscEnable;
		logic extSyncBypass;
		logic countSourceSelect;
		logic counterRun;
	} stc_control_t;

	typedef struct packed {
		logic [1:0] portCDirection;
		logic [1:0] pinLevel;
	} stc_pins_t;

endpackage

// File: stc_timer.sv
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - wide-access bit makes 16-bit atomic access
// - prescale field divides by 1,2,4,8
// - bit 3 enables low-power oscillator
// - bit 2 set counts external unsynchronised
// - internal source ignores synchronisation bit
// - bit 1 selects internal or external edge
// - bit 0 runs or stops counter
// - bit 6 reads as zero
// - internal source advances every instruction cycle
// - external source counts rising edges, oscillator
// - oscillator pins forced input, read zero
// - oscillator keeps running during sleep
// - count wraps FFFF to 0000, sets flag
// - interrupt only while enable bit set
// - special event trigger resets counter, starts conversion
// - trigger reset never sets overflow flag
// - trigger reset unreliable in asynchronous mode
// - counter write beats trigger reset
// - wide mode high address is buffer
// - wide low read copies high byte
// - wide low write loads high from buffer
// - only low write clears prescaler
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
module stc_timer (
	// system
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite write address
	input wire logic [stc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [stc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// count inputs
	input wire logic externalCountPin,
	input wire logic oscInputPin,
	// compare unit
	input wire logic [3:0] compareModeSelect,
	input wire logic specialEventTrig,
	input wire logic adcEnabled,
	output logic adcStart,
	// port c pins shared with the oscillator
	input wire stc_pkg::stc_pins_t portPins,
	output logic [1:0] pinDirEff,
	output logic [1:0] pinReadEff,
	// oscillator and interrupt
	output logic oscRun,
	output logic overflowIrq
);
	import stc_pkg::*;

	function automatic logic [2:0] prescaleLast(input logic [1:0] sel);
		prescaleLast = 3'((4'h1 << sel) - 4'h1);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == OFF_CONTROL) || (a == OFF_COUNT_LOW) || (a == OFF_COUNT_HIGH) ||
			(a == OFF_FLAGS_ONE) || (a == OFF_ENABLES_ONE);
	endfunction

	stc_control_t control_r;
	logic [15:0] count_r;
	logic [7:0] highBuf_r;
	logic [2:0] prescale_r;
	logic [1:0] instrDiv_r;
	logic overflowFlag_r;
	logic overflowIrqEn_r;
	logic syncA_r, syncB_r, syncPrev_r, asyncPrev_r;

	logic awHeld_r, wHeld_r;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic adcStart_r, oscRun_r, overflowIrq_r;
	logic [1:0] pinDirEff_r, pinReadEff_r;

	//////////////////////////////////////////////////////////////////////////////
	// bus decode

	logic doWrite, byteWr, lowWr, highWr, ctrlWr, flagsWr, enWr;
	logic doRead, lowRd;
	logic [7:0] wByte;

	assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
	assign byteWr = doWrite && wStrb_r[0];
	assign wByte = wData_r[7:0];
	assign lowWr = byteWr && (awAddr_r == OFF_COUNT_LOW);
	assign highWr = byteWr && (awAddr_r == OFF_COUNT_HIGH);
	assign ctrlWr = byteWr && (awAddr_r == OFF_CONTROL);
	assign flagsWr = byteWr && (awAddr_r == OFF_FLAGS_ONE);
	assign enWr = byteWr && (awAddr_r == OFF_ENABLES_ONE);
	assign doRead = s_axi_arvalid && arready_r;
	assign lowRd = doRead && (s_axi_araddr == OFF_COUNT_LOW);

	//////////////////////////////////////////////////////////////////////////////
	// count source and prescaler

	logic srcLevel, syncEdge, asyncEdge, instrTick, countTick, incEn, asyncMode, trigReset;

	// the oscillator, when on, drives the count input in place of the pin
	assign srcLevel = control_r.lowPowerOscEnable ? oscInputPin : externalCountPin;
	assign syncEdge = syncB_r && !syncPrev_r;
	assign asyncEdge = srcLevel && !asyncPrev_r;
	assign instrTick = (instrDiv_r == INSTR_DIV_LAST);
	assign asyncMode = control_r.countSourceSelect && control_r.extSyncBypass;

	always_comb begin
		if (!control_r.countSourceSelect) begin
			countTick = instrTick;
		end else if (control_r.extSyncBypass) begin
			countTick = asyncEdge;
		end else begin
			countTick = syncEdge;
		end
	end

	assign incEn = control_r.counterRun && countTick &&
		(prescale_r == prescaleLast(control_r.inputPrescaleSelect));

	// the reset is withheld in asynchronous counting; software must not rely on it there
	assign trigReset = specialEventTrig && (compareModeSelect == CMP_MODE_SPECIAL) && !asyncMode;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			instrDiv_r <= 2'h0;
		end else begin
			instrDiv_r <= 2'(instrDiv_r + 2'h1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			syncA_r <= 1'b0;
			syncB_r <= 1'b0;
			syncPrev_r <= 1'b0;
			asyncPrev_r <= 1'b0;
		end else begin
			syncA_r <= srcLevel;
			syncB_r <= syncA_r;
			syncPrev_r <= syncB_r;
			asyncPrev_r <= srcLevel;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prescale_r <= 3'h0;
		end else if (lowWr) begin
			prescale_r <= 3'h0;
		end else if (control_r.counterRun && countTick) begin
			if (prescale_r >= prescaleLast(control_r.inputPrescaleSelect)) begin
				prescale_r <= 3'h0;
			end else begin
				prescale_r <= 3'(prescale_r + 3'h1);
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// counter, high buffer, flags

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_r <= COUNT_RST;
		end else if (lowWr) begin
			if (control_r.wideAccessEnable) begin
				count_r <= {highBuf_r, wByte};
			end else begin
				count_r <= {count_r[15:8], wByte};
			end
		end else if (highWr && !control_r.wideAccessEnable) begin
			count_r <= {wByte, count_r[7:0]};
		end else if (trigReset) begin
			count_r <= COUNT_RST;
		end else if (incEn) begin
			count_r <= 16'(count_r + 16'h0001);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			highBuf_r <= HIGH_BUF_RST;
		end else if (highWr && control_r.wideAccessEnable) begin
			highBuf_r <= wByte;
		end else if (lowRd && control_r.wideAccessEnable) begin
			highBuf_r <= count_r[15:8];
		end
	end

	logic wrapEvent;
	// a wrap only counts when the increment really lands; writes and trigger resets win
	// a wide-mode high write only touches the buffer, so the increment still lands then
	assign wrapEvent = incEn && (count_r == COUNT_MAX) && !lowWr &&
		!(highWr && !control_r.wideAccessEnable) && !trigReset;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			overflowFlag_r <= 1'b0;
		end else if (wrapEvent) begin
			overflowFlag_r <= 1'b1;
		end else if (flagsWr) begin
			overflowFlag_r <= wByte[OVF_FLAG_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			overflowIrqEn_r <= 1'b0;
		end else if (enWr) begin
			overflowIrqEn_r <= wByte[OVF_IRQ_EN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			control_r <= CONTROL_RST;
		end else if (ctrlWr) begin
			control_r <= wByte & CONTROL_WMASK;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// side outputs

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			overflowIrq_r <= 1'b0;
			adcStart_r <= 1'b0;
			oscRun_r <= 1'b0;
			pinDirEff_r <= 2'h3;
			pinReadEff_r <= 2'h0;
		end else begin
			overflowIrq_r <= overflowFlag_r && overflowIrqEn_r;
			adcStart_r <= specialEventTrig && (compareModeSelect == CMP_MODE_SPECIAL) && adcEnabled;
			// no sleep gating: the oscillator follows its enable alone
			oscRun_r <= control_r.lowPowerOscEnable;
			if (control_r.lowPowerOscEnable) begin
				pinDirEff_r <= 2'h3;
				pinReadEff_r <= 2'h0;
			end else begin
				pinDirEff_r <= portPins.portCDirection;
				pinReadEff_r <= portPins.pinLevel;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel: one write in flight

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
				awready_r <= 1'b0;
			end
			if (s_axi_wvalid && wready_r) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
				wready_r <= 1'b0;
			end
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= mapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// axi4-lite read channel

	logic [7:0] rdByte;
	always_comb begin
		case (s_axi_araddr)
			OFF_CONTROL: rdByte = control_r;
			OFF_COUNT_LOW: rdByte = count_r[7:0];
			OFF_COUNT_HIGH: rdByte = control_r.wideAccessEnable ? highBuf_r : count_r[15:8];
			OFF_FLAGS_ONE: rdByte = {7'h00, overflowFlag_r};
			OFF_ENABLES_ONE: rdByte = {7'h00, overflowIrqEn_r};
			default: rdByte = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end else if (doRead) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= {24'h000000, rdByte};
			rresp_r <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign adcStart = adcStart_r;
	assign oscRun = oscRun_r;
	assign overflowIrq = overflowIrq_r;
	assign pinDirEff = pinDirEff_r;
	assign pinReadEff = pinReadEff_r;

endmodule // stc_timer

// File: stc_timer_checker.sv
module stc_timer_checker import stc_pkg::*; (
	// system
	input wire logic clk,
	input wire logic rst_n,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// compare unit
	input wire logic [3:0] compareModeSelect,
	input wire logic specialEventTrig,
	input wire logic adcEnabled,
	input wire logic adcStart,
	// pins and oscillator
	input wire stc_pins_t portPins,
	input wire logic [1:0] pinDirEff,
	input wire logic [1:0] pinReadEff,
	input wire logic oscRun
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [ADDR_W-1:0] lastRd_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////
	// remembers the address of the read being answered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lastRd_r <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			lastRd_r <= s_axi_araddr;
		end
	end
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence trigSpecial;
		specialEventTrig && compareModeSelect == CMP_MODE_SPECIAL && adcEnabled;
	endsequence
	////////////////////////////////////////////////////////////////////////////
	a_pin_dir_forced: assert property (oscRun |-> pinDirEff == 2'h3)
		else $error("pin direction not forced to input");
	a_pin_read_zero: assert property (oscRun |-> pinReadEff == 2'h0)
		else $error("pin read not zero");
	a_pin_pass: assert property (!oscRun && $past(rst_n) |->
		pinDirEff == $past(portPins.portCDirection) && pinReadEff == $past(portPins.pinLevel))
		else $error("pins not passed through");
	a_adc_start_cause: assert property (trigSpecial |=> adcStart)
		else $error("conversion start missing");
	a_adc_start_only: assert property (adcStart |-> $past(specialEventTrig && adcEnabled
		&& compareModeSelect == CMP_MODE_SPECIAL))
		else $error("conversion start without trigger");
	a_control_bit_six: assert property (s_axi_rvalid && lastRd_r == OFF_CONTROL |->
		s_axi_rdata[31:6] == 26'h0 || s_axi_rdata[31:6] == 26'h2)
		else $error("control bit six not zero");
	a_write_answer: assert property (wrTaken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule // stc_timer_checker

// File: stc_timer_bench.sv
module stc_timer_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import stc_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] s_axi_awaddr = '0;
	logic [7:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic externalCountPin = 1'h0, oscInputPin = 1'h0, specialEventTrig = 1'h0, adcEnabled = 1'h1;
	logic [3:0] compareModeSelect = '0;
	stc_pins_t portPins = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, adcStart, oscRun, overflowIrq;
	logic [1:0] s_axi_bresp, s_axi_rresp, pinDirEff, pinReadEff;
	logic [31:0] s_axi_rdata, got;
	int mismatches = 0, check_count = 0, n;
	int mCtl = 0, mCount = 0, mBuf = 0;
	logic [7:0] ctl [3] = '{8'h03, 8'h07, 8'h0b};
	always #2.5 clk = ~clk;
	stc_timer dut (
		.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.externalCountPin(externalCountPin), .oscInputPin(oscInputPin),
		.compareModeSelect(compareModeSelect), .specialEventTrig(specialEventTrig),
		.adcEnabled(adcEnabled), .adcStart(adcStart),
		.portPins(portPins), .pinDirEff(pinDirEff), .pinReadEff(pinReadEff),
		.oscRun(oscRun), .overflowIrq(overflowIrq)
	);
	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// reference model of the register side; counting is not modelled, so count
	// expectations from it only hold after both bytes were written
	function automatic void modelWrite(input logic [7:0] a, input logic [7:0] d);
		case (a)
			OFF_CONTROL: begin
				mCtl = d;
				mCtl[6] = 1'b0;
			end
			OFF_COUNT_LOW: begin
				if (mCtl[7]) begin
					mCount = (mBuf << 8) | int'(d);
				end else begin
					mCount = (mCount & 32'h0000ff00) | int'(d);
				end
			end
			OFF_COUNT_HIGH: begin
				if (mCtl[7]) begin
					mBuf = d;
				end else begin
					mCount = (mCount & 32'h000000ff) | (int'(d) << 8);
				end
			end
			default: begin
			end
		endcase
	endfunction
	function automatic int modelRead(input logic [7:0] a);
		modelRead = 0;
		if (a == OFF_CONTROL) begin
			modelRead = mCtl;
		end
		if (a == OFF_COUNT_LOW) begin
			modelRead = mCount & 32'h000000ff;
			if (mCtl[7]) begin
				mBuf = mCount >> 8;
			end
		end
		if (a == OFF_COUNT_HIGH) begin
			modelRead = mCtl[7] ? mBuf : (mCount >> 8);
		end
	endfunction
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		if (s_axi_wstrb[0]) modelWrite(a, d);
		chk(s_axi_bresp, (a > OFF_ENABLES_ONE) ? RESP_SLVERR : RESP_OKAY);
	endtask
	task get(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		got = s_axi_rdata;
		chk(s_axi_rresp, (a > OFF_ENABLES_ONE) ? RESP_SLVERR : RESP_OKAY);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		get(a);
		chk(got, e);
	endtask
	task results;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("mismatch at %0t: timeout", $time);
		results();
	end
	initial begin
		void'($urandom(47673));
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		portPins <= 4'($urandom);
		for (int a = 0; a < 24; a += 4) rd(8'(a), 0);
		wr(OFF_CONTROL, 8'hff);
		rd(OFF_CONTROL, modelRead(OFF_CONTROL));
		repeat (2) @(posedge clk);
		chk(oscRun, 1);
		chk({pinDirEff, pinReadEff}, 4'hc);
		$display("test registers done");
		// counting window is 20 ticks; bus latency and divider phase give a little slack
		for (int p = 0; p < 4; p++) begin
			wr(OFF_CONTROL, 0);
			wr(OFF_COUNT_LOW, 0);
			wr(OFF_CONTROL, {2'h0, p[1:0], 4'h5});
			repeat (80 << p) @(posedge clk);
			wr(OFF_CONTROL, 0);
			get(OFF_COUNT_LOW);
			chk(got >= 19 && got <= 22, 1);
			repeat (40) @(posedge clk);
			rd(OFF_COUNT_LOW, got);
		end
		$display("test prescale done");
		for (int m = 0; m < 3; m++) begin
			wr(OFF_CONTROL, 0);
			wr(OFF_COUNT_LOW, 0);
			wr(OFF_CONTROL, ctl[m]);
			repeat (4) @(posedge clk); // let the new count source take effect before counting
			n = $urandom_range(20, 1);
			repeat (n) begin
				{oscInputPin, externalCountPin} <= (m == 2) ? 2'h2 : 2'h1;
				repeat (4) @(posedge clk);
				{oscInputPin, externalCountPin} <= 2'h0;
				repeat (4) @(posedge clk);
			end
			repeat (8) @(posedge clk);
			rd(OFF_COUNT_LOW, n);
		end
		$display("test external done");
		wr(OFF_CONTROL, 0);
		wr(OFF_ENABLES_ONE, 1);
		wr(OFF_COUNT_HIGH, 8'hff);
		wr(OFF_COUNT_LOW, 8'hfe);
		wr(OFF_CONTROL, 1);
		repeat (20) @(posedge clk);
		wr(OFF_CONTROL, 0);
		rd(OFF_FLAGS_ONE, 1);
		rd(OFF_COUNT_HIGH, 0);
		chk(overflowIrq, 1);
		wr(OFF_ENABLES_ONE, 0);
		repeat (2) @(posedge clk);
		chk(overflowIrq, 0);
		wr(OFF_FLAGS_ONE, 0);
		rd(OFF_FLAGS_ONE, 0);
		$display("test overflow done");
		for (int k = 0; k < 3; k++) begin
			// the last pass runs with the converter off so no start may follow
			adcEnabled <= (k != 2);
			wr(OFF_COUNT_LOW, 8'h40);
			wr(OFF_CONTROL, (k == 2) ? 8'h07 : 8'h00);
			compareModeSelect <= (k == 0) ? 4'($urandom_range(10, 0)) : CMP_MODE_SPECIAL;
			@(posedge clk) specialEventTrig <= 1'h1;
			@(posedge clk) specialEventTrig <= 1'h0;
			@(negedge clk) chk(adcStart, (k == 1) ? 1 : 0);
			rd(OFF_COUNT_LOW, (k == 1) ? 0 : 8'h40);
			rd(OFF_FLAGS_ONE, 0);
		end
		wr(OFF_CONTROL, 0);
		fork
			wr(OFF_COUNT_LOW, 8'h55);
			begin
				repeat (2) @(posedge clk);
				specialEventTrig <= 1'h1;
				@(posedge clk) specialEventTrig <= 1'h0;
			end
		join
		rd(OFF_COUNT_LOW, 8'h55);
		$display("test trigger done");
		wr(OFF_CONTROL, 8'h80);
		wr(OFF_COUNT_HIGH, 8'h12);
		wr(OFF_COUNT_LOW, 8'h34);
		rd(OFF_COUNT_LOW, modelRead(OFF_COUNT_LOW));
		rd(OFF_COUNT_HIGH, modelRead(OFF_COUNT_HIGH));
		wr(OFF_COUNT_HIGH, 8'h56);
		rd(OFF_COUNT_HIGH, modelRead(OFF_COUNT_HIGH));
		rd(OFF_COUNT_LOW, modelRead(OFF_COUNT_LOW));
		rd(OFF_COUNT_HIGH, modelRead(OFF_COUNT_HIGH));
		wr(OFF_CONTROL, 0);
		wr(OFF_COUNT_HIGH, 8'h77);
		rd(OFF_COUNT_HIGH, modelRead(OFF_COUNT_HIGH));
		rd(OFF_COUNT_LOW, modelRead(OFF_COUNT_LOW));
		// a write without its low byte lane must leave the counter alone
		s_axi_wstrb <= 4'he;
		wr(OFF_COUNT_LOW, 8'h99);
		s_axi_wstrb <= 4'hf;
		rd(OFF_COUNT_LOW, modelRead(OFF_COUNT_LOW));
		$display("test wide access done");
		results();
	end
endmodule // stc_timer_bench

bind stc_timer stc_timer_checker checker_i (
	.clk(clk), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.compareModeSelect(compareModeSelect), .specialEventTrig(specialEventTrig),
	.adcEnabled(adcEnabled), .adcStart(adcStart),
	.portPins(portPins), .pinDirEff(pinDirEff), .pinReadEff(pinReadEff),
	.oscRun(oscRun)
);
